// [design/lcdsp_cfg.svh]
// constants of the lcd driver serial host port: offsets, fields, reset values
// assumes inclusion by bare name from the package and the design modules
//
// What this block does
// - SDA changes only while SCL is low
// - detect START and STOP while SCL high
// - acknowledge every byte received in writes
// - read ends only on STOP or START
// - first write byte loads pointer; invalid ignored
// - pointer advances per byte, saturates at 18h
// - writes accept zero or more data bytes
// - reads start at the current pointer
// - read data driven right after address ack
// - address: fixed prefix plus two strap bits
// - address bit 0 selects write or read
// - SPI uses enable, clock, one data line
// - high enable resets SPI; falling starts it
// - SPI samples on rise, drives after fall
// - SPI bytes shift most significant bit first
// - SPI header: direction, zero bits, pointer
// - SPI invalid pointer ignores the transaction
// - SPI pointer advances after each byte written and at each read byte fetch
// - SPI read drives bytes until enable rises
`ifndef LCDSP_CFG_SVH
`define LCDSP_CFG_SVH

`define LCDSP_NUM_REGS     24
`define LCDSP_PTR_LAST     5'h17
`define LCDSP_PTR_SAT      5'h18
`define LCDSP_PTR_RST      5'h00
`define LCDSP_REG_RST      8'h00
`define LCDSP_RD_EMPTY     8'h00
`define LCDSP_I2C_RW_BIT   0
`define LCDSP_SPI_RW_BIT   7
`define LCDSP_SPI_Z_MSB    6
`define LCDSP_SPI_Z_LSB    5
`define LCDSP_BIT_LAST     3'h7
`define LCDSP_SYNC_RST     7'h78

`endif

// [design/lcdsp_pkg.sv]
// types of the lcd driver serial host port
// assumes the constants header sits beside it
`include "lcdsp_cfg.svh"
package lcdsp_pkg;
    // byte-level phases of the two-wire target
    typedef enum logic [2:0] {
        LCDSP_I_IDLE,
        LCDSP_I_RX,
        LCDSP_I_ACK,
        LCDSP_I_TX,
        LCDSP_I_RACK
    } lcdsp_i2c_st_t;
    typedef logic [4:0] lcdsp_ptr_t;
    typedef logic [7:0] lcdsp_byte_t;
endpackage

// [design/lcdsp_sync.sv]
// two-flop synchroniser for a bundle of pin inputs
// assumes each bit is an independent level; no bus coherence
module lcdsp_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic         clk,    // block clock
    input  wire logic         rst,    // synchronous reset
    input  wire logic [W-1:0] d,      // asynchronous pins
    output logic      [W-1:0] q       // synchronised levels
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [design/lcdsp_port.sv]
// serial host port: two-wire target and three-wire spi into 24 registers
// assumes bus clocks well below clk/4; pins are asynchronous to clk
`include "lcdsp_cfg.svh"
module lcdsp_port
    import lcdsp_pkg::*;
#(
    parameter logic [4:0] ADDR_PREFIX = 5'h15  // arbitrary value
) (
    input  wire logic         clk,             // 10 MHz block clock
    input  wire logic         rst,             // synchronous, active high
    input  wire logic         if_sel,          // 0 two-wire, 1 spi
    input  wire logic         addr_strap_low,  // address bit 1 strap
    input  wire logic         addr_strap_high, // address bit 2 strap
    input  wire logic         i2c_scl,         // two-wire clock pin
    input  wire logic         sda_in,          // two-wire data level
    output logic              sda_out,         // always low when enabled
    output logic              sda_oe,          // high pulls data low
    input  wire logic         spi_ce_n,        // spi chip enable, low active
    input  wire logic         spi_sclk,        // spi clock pin
    input  wire logic         sdio_in,         // spi data level
    output logic              sdio_out,        // spi data driven
    output logic              sdio_oe,         // high while driving
    output logic [4:0]        ptr_out,         // current register pointer
    output logic [191:0]      regs_flat        // register 0 in low byte
);
    // synchronised pins
    logic        scl_s, sda_s, ce_n_s, sdio_s, sclk_s, strap_h_s, strap_l_s;
    logic        scl_d_r, sda_d_r, sclk_d_r;
    logic        scl_rise, scl_fall, sda_rise, sda_fall, start_c, stop_c;
    logic        sclk_rise, sclk_fall;

    // register file and pointer
    lcdsp_byte_t mem_r [`LCDSP_NUM_REGS];
    lcdsp_ptr_t  ptr_r;

    // two-wire state
    lcdsp_i2c_st_t i_st_r;
    logic [2:0]  i_cnt_r;
    logic [1:0]  i_idx_r;
    logic        i_got_r, i_rd_r, i_ign_r;
    lcdsp_byte_t i_sh_r, i_tx_r;
    logic        i_done, i_ptr_ld, i_wr, i_rd_ld;

    // spi state
    logic        s_act;
    logic [2:0]  s_cnt_r;
    logic        s_hdr_r, s_rd_r, s_ign_r, s_txv_r;
    lcdsp_byte_t s_sh_r, s_tx_r, s_b;
    logic        s_ptr_ld, s_wr, s_rd_ld, s_hdr_ok;

    // saturating pointer step
    function automatic lcdsp_ptr_t ptr_step(input lcdsp_ptr_t p);
        ptr_step = (p >= `LCDSP_PTR_SAT) ? `LCDSP_PTR_SAT : p + 5'h01;
    endfunction

    // register read; the parking slot past the end reads as empty
    function automatic lcdsp_byte_t rd_byte(input lcdsp_ptr_t p);
        rd_byte = (p <= `LCDSP_PTR_LAST) ? mem_r[p] : `LCDSP_RD_EMPTY;
    endfunction

    function automatic logic ptr_ok(input lcdsp_ptr_t p);
        ptr_ok = (p <= `LCDSP_PTR_LAST);
    endfunction

    lcdsp_sync #(
        .W       (7),
        .RST_VAL (`LCDSP_SYNC_RST)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({i2c_scl, sda_in, spi_ce_n, sdio_in, spi_sclk,
               addr_strap_high, addr_strap_low}),
        .q   ({scl_s, sda_s, ce_n_s, sdio_s, sclk_s, strap_h_s, strap_l_s})
    );

    // previous levels for edge finding
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            scl_d_r  <= scl_s;
            sda_d_r  <= sda_s;
            sclk_d_r <= sclk_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign sda_rise  = sda_s & ~sda_d_r;
    assign sda_fall  = ~sda_s & sda_d_r;
    // data edge with clock high both cycles is a bus condition
    assign start_c   = ~if_sel & scl_s & scl_d_r & sda_fall;
    assign stop_c    = ~if_sel & scl_s & scl_d_r & sda_rise;
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;

    // two-wire byte events, all taken on the clock fall after a byte
    assign i_done   = (i_st_r == LCDSP_I_RX) & scl_fall & i_got_r;
    assign i_ptr_ld = i_done & (i_idx_r == 2'd1) & ptr_ok(i_sh_r[4:0])
                      & (i_sh_r[7:5] == 3'b000);
    assign i_wr     = i_done & (i_idx_r == 2'd2) & ~i_ign_r;
    // next read byte loads on the fall ending an ack slot
    assign i_rd_ld  = scl_fall & ((i_st_r == LCDSP_I_ACK & i_rd_r)
                      | (i_st_r == LCDSP_I_RACK));

    // two-wire sequencer; START restarts from any phase
    always_ff @(posedge clk) begin
        if (rst || if_sel) begin
            i_st_r  <= LCDSP_I_IDLE;
            i_cnt_r <= 3'h0;
            i_idx_r <= 2'd0;
            i_got_r <= 1'b0;
            i_rd_r  <= 1'b0;
            i_ign_r <= 1'b0;
            i_sh_r  <= 8'h00;
            i_tx_r  <= 8'h00;
        end else if (start_c) begin
            i_st_r  <= LCDSP_I_RX;
            i_cnt_r <= 3'h0;
            i_idx_r <= 2'd0;
            i_got_r <= 1'b0;
            i_rd_r  <= 1'b0;
            i_ign_r <= 1'b0;
        end else if (stop_c) begin
            i_st_r  <= LCDSP_I_IDLE;
            i_got_r <= 1'b0;
        end else begin
            unique case (i_st_r)
                LCDSP_I_IDLE: begin
                    i_cnt_r <= 3'h0;
                end
                LCDSP_I_RX: begin
                    if (scl_rise) begin
                        i_sh_r  <= {i_sh_r[6:0], sda_s};
                        i_cnt_r <= i_cnt_r + 3'h1;
                        if (i_cnt_r == `LCDSP_BIT_LAST) begin
                            i_got_r <= 1'b1;
                        end
                    end else if (i_done) begin
                        i_got_r <= 1'b0;
                        i_cnt_r <= 3'h0;
                        if (i_idx_r == 2'd0 &&
                            i_sh_r[7:1] != {ADDR_PREFIX, strap_h_s, strap_l_s}) begin
                            i_st_r <= LCDSP_I_IDLE;
                        end else begin
                            i_st_r <= LCDSP_I_ACK;
                        end
                        if (i_idx_r == 2'd0) begin
                            i_rd_r <= i_sh_r[`LCDSP_I2C_RW_BIT];
                        end
                        if (i_idx_r == 2'd1) begin
                            // bad pointer voids the rest, acks still given
                            i_ign_r <= ~i_ptr_ld;
                        end
                        if (i_idx_r != 2'd2) begin
                            i_idx_r <= i_idx_r + 2'd1;
                        end
                    end
                end
                LCDSP_I_ACK: begin
                    if (scl_fall) begin
                        if (i_rd_r) begin
                            i_st_r  <= LCDSP_I_TX;
                            i_tx_r  <= rd_byte(ptr_r);
                            i_cnt_r <= 3'h0;
                        end else begin
                            i_st_r <= LCDSP_I_RX;
                        end
                    end
                end
                LCDSP_I_TX: begin
                    // shift only on the fall so SDA moves while SCL is low
                    if (scl_fall) begin
                        if (i_cnt_r == `LCDSP_BIT_LAST) begin
                            i_st_r <= LCDSP_I_RACK;
                        end else begin
                            i_tx_r  <= {i_tx_r[6:0], 1'b0};
                            i_cnt_r <= i_cnt_r + 3'h1;
                        end
                    end
                end
                LCDSP_I_RACK: begin
                    // controller ack level is not looked at
                    if (scl_fall) begin
                        i_st_r  <= LCDSP_I_TX;
                        i_tx_r  <= rd_byte(ptr_r);
                        i_cnt_r <= 3'h0;
                    end
                end
            endcase
        end
    end

    // open drain: release for ones, pull for zeros and acks
    assign sda_out = 1'b0;
    assign sda_oe  = ~if_sel & ((i_st_r == LCDSP_I_ACK)
                     | (i_st_r == LCDSP_I_TX & ~i_tx_r[7]));

    // spi runs only while enable is low
    assign s_act    = if_sel & ~ce_n_s;
    assign s_b      = {s_sh_r[6:0], sdio_s};
    assign s_hdr_ok = (s_b[`LCDSP_SPI_Z_MSB:`LCDSP_SPI_Z_LSB] == 2'b00)
                      & ptr_ok(s_b[4:0]);
    assign s_ptr_ld = s_act & sclk_rise & (s_cnt_r == `LCDSP_BIT_LAST)
                      & ~s_hdr_r & s_hdr_ok;
    assign s_wr     = s_act & sclk_rise & (s_cnt_r == `LCDSP_BIT_LAST)
                      & s_hdr_r & ~s_rd_r & ~s_ign_r;
    assign s_rd_ld  = s_act & sclk_fall & s_hdr_r & s_rd_r & ~s_ign_r
                      & (s_cnt_r == 3'h0);

    // spi receiver; raised enable clears any half byte
    always_ff @(posedge clk) begin
        if (rst || !s_act) begin
            s_cnt_r <= 3'h0;
            s_hdr_r <= 1'b0;
            s_rd_r  <= 1'b0;
            s_ign_r <= 1'b0;
            s_sh_r  <= 8'h00;
        end else if (sclk_rise) begin
            s_sh_r  <= s_b;
            s_cnt_r <= s_cnt_r + 3'h1;
            if (s_cnt_r == `LCDSP_BIT_LAST && !s_hdr_r) begin
                s_hdr_r <= 1'b1;
                s_rd_r  <= s_b[`LCDSP_SPI_RW_BIT];
                s_ign_r <= ~s_hdr_ok;
            end
        end
    end

    // spi transmitter; next bit appears after each falling clock
    always_ff @(posedge clk) begin
        if (rst || !s_act) begin
            s_tx_r  <= 8'h00;
            s_txv_r <= 1'b0;
        end else if (s_rd_ld) begin
            s_tx_r  <= rd_byte(ptr_r);
            s_txv_r <= 1'b1;
        end else if (sclk_fall && s_txv_r) begin
            s_tx_r  <= {s_tx_r[6:0], 1'b0};
        end
    end

    assign sdio_out = s_tx_r[7];
    assign sdio_oe  = s_act & s_txv_r;

    // one pointer shared by both ports; only the selected one acts
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_r <= `LCDSP_PTR_RST;
        end else if (i_ptr_ld) begin
            ptr_r <= i_sh_r[4:0];
        end else if (s_ptr_ld) begin
            ptr_r <= s_b[4:0];
        end else if (i_wr || i_rd_ld || s_wr || s_rd_ld) begin
            ptr_r <= ptr_step(ptr_r);
        end
    end

    // register writes; the parking slot past the end holds nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int k = 0; k < `LCDSP_NUM_REGS; k++) begin
                mem_r[k] <= `LCDSP_REG_RST;
            end
        end else if (ptr_ok(ptr_r)) begin
            if (i_wr) begin
                mem_r[ptr_r] <= i_sh_r;
            end else if (s_wr) begin
                mem_r[ptr_r] <= s_b;
            end
        end
    end

    // flatten registers for the display logic
    always_comb begin
        regs_flat = '0;
        for (int k = 0; k < `LCDSP_NUM_REGS; k++) begin
            regs_flat[k*8 +: 8] = mem_r[k];
        end
    end

    assign ptr_out = ptr_r;
endmodule

// [dv/lcdsp_port_monitor.sv]
// checker for the serial host port: pin timing and pointer range
// assumes it is bound to lcdsp_port and sees one clock domain
module lcdsp_port_monitor (
    input wire logic       clk,      // block clock
    input wire logic       rst,      // sync reset
    input wire logic       if_sel,   // port select
    input wire logic       i2c_scl,  // two-wire clock
    input wire logic       sda_out,  // data drive level
    input wire logic       sda_oe,   // data pull enable
    input wire logic       spi_ce_n, // chip enable
    input wire logic       spi_sclk, // spi clock
    input wire logic       sdio_out, // spi data out
    input wire logic       sdio_oe,  // spi drive enable
    input wire logic [4:0] ptr_out   // pointer
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // open-drain line and its bus-condition hazard
    a_sda_pull_low: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !i2c_scl)
        else $error("data moved while clock high");
    // spi data moves only after a falling clock, only while enabled
    a_sdio_fall: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> !spi_sclk)
        else $error("spi data moved while clock high");
    a_spi_idle_off: assert property (spi_ce_n [*6] |-> !sdio_oe)
        else $error("spi data driven with enable high");
    a_oe_needs_ce: assert property (sdio_oe |-> !$past(spi_ce_n, 6))
        else $error("spi data driven without a transaction");
    // the idle port stays off the wire
    a_i2c_quiet: assert property (if_sel [*6] |-> !sda_oe)
        else $error("two-wire driven in spi mode");
    a_spi_quiet: assert property (!if_sel [*6] |-> !sdio_oe)
        else $error("spi driven in two-wire mode");
    // pointer never passes the saturation value
    a_ptr_range: assert property (ptr_out <= 5'h18)
        else $error("pointer beyond saturation");
    a_rst_clear: assert property ($fell(rst) |-> ptr_out == 5'h00 && !sda_oe && !sdio_oe)
        else $error("state not cleared by reset");
    c_ack: cover property ($rose(sda_oe));
    c_spi_rd: cover property ($rose(sdio_oe));
    c_sat: cover property (ptr_out == 5'h18);
endmodule

bind lcdsp_port lcdsp_port_monitor u_mon (.clk(clk), .rst(rst), .if_sel(if_sel),
    .i2c_scl(i2c_scl), .sda_out(sda_out), .sda_oe(sda_oe), .spi_ce_n(spi_ce_n),
    .spi_sclk(spi_sclk), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .ptr_out(ptr_out));

// [dv/lcdsp_host_model.sv]
// host model: two-wire controller and three-wire spi host, 800 ns bit period
// assumes the bench resolves both data wires and calls these tasks
module lcdsp_host_model (
    input wire logic clk,    // bench clock
    input wire logic sda_w,  // resolved two-wire data
    input wire logic sdio_w, // resolved spi data
    output logic     scl,    // two-wire clock
    output logic     sda_lo, // pulls data low
    output logic     ce_n,   // chip enable
    output logic     sclk,   // spi clock
    output logic     sdio_h  // spi data, pattern when released
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       drv;   // host drives spi data
    logic [7:0] got_v; // last answered byte
    event       got;   // one answer ready
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
        ce_n = 1'b1;
        sclk = 1'b0;
        drv = 1'b0;
        sdio_h = 1'b0;
    end
    // released line shows a moving pattern, never the last value
    always @(posedge clk) begin
        if (!drv) sdio_h <= ~sdio_h;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // start only from an idle or clock-low bus
    task automatic i2c_start();
        tick(2);
        sda_lo = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_lo = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic i2c_stop();
        tick(1);
        sda_lo = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_lo = 1'b0;
        tick(4);
    endtask
    // data set in the low phase, held through the high phase
    task automatic i2c_bit(input logic b, output logic r);
        tick(1);
        sda_lo = !b;
        tick(4);
        scl = 1'b1;
        r = sda_w;
        tick(3);
        scl = 1'b0;
    endtask
    // reads are always acked; the last one ends by a stop in its ack slot
    task automatic i2c_byte(input logic [7:0] tx, input logic rd, input logic last);
        logic [7:0] rx;
        logic       a;
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        if (rd && last) i2c_stop();
        else i2c_bit(!rd, a);
        got_v = rd ? rx : {7'h00, a};
        -> got;
    endtask
    // enable pulled low per transaction and raised after it
    task automatic spi_on();
        ce_n = 1'b0;
        tick(4);
    endtask
    task automatic spi_off();
        tick(4);
        ce_n = 1'b1;
        drv = 1'b0;
        tick(8);
    endtask
    // msb first, host samples at the rise
    task automatic spi_bits(input logic [7:0] tx, input int n, input logic rd);
        logic [7:0] rx;
        for (int i = 7; i > 7 - n; i--) begin
            tick(1);
            drv = !rd;
            if (!rd) sdio_h = tx[i];
            tick(4);
            sclk = 1'b1;
            rx[i] = sdio_w;
            tick(3);
            sclk = 1'b0;
        end
        got_v = rx;
        if (rd) -> got;
    endtask
endmodule

// [dv/lcdsp_port_bench.sv]
// bench for the serial host port: both ports against a scoreboard
// assumes the host model and the design files are compiled first
module lcdsp_port_bench
    import lcdsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] PFX = 5'h15; // arbitrary address prefix
    logic         clk, rst, if_sel, sh, sl, sda_oe, sda_out, sdio_oe, sdio_out;
    logic         scl, sda_lo, ce_n, sclk, sdio_h;
    logic [4:0]   ptr;
    logic [191:0] regs;
    logic [7:0]   p;
    lcdsp_byte_t  mreg [24];
    lcdsp_byte_t  exp_q [$];
    logic [31:0]  seed = 32'h58;
    int           errors, n_tests, mp;
    wire          sda_w  = ~((sda_oe & ~sda_out) | sda_lo); // pull-up
    wire          sdio_w = sdio_oe ? sdio_out : sdio_h;
    initial clk = 1'b0;
    always #50 clk = ~clk;
    lcdsp_port #(.ADDR_PREFIX(PFX)) u_dut (.clk(clk), .rst(rst), .if_sel(if_sel),
        .addr_strap_low(sl), .addr_strap_high(sh), .i2c_scl(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .spi_ce_n(ce_n), .spi_sclk(sclk),
        .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .ptr_out(ptr),
        .regs_flat(regs));
    lcdsp_host_model u_host (.clk(clk), .sda_w(sda_w), .sdio_w(sdio_w), .scl(scl),
        .sda_lo(sda_lo), .ce_n(ce_n), .sclk(sclk), .sdio_h(sdio_h));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk_w(input lcdsp_byte_t g, input lcdsp_byte_t e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: answer %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_s(input lcdsp_byte_t g, input lcdsp_byte_t e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: state %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_all();
        for (int k = 0; k < 24; k++) chk_s(regs[8*k +: 8], mreg[k]);
        chk_s({3'h0, ptr}, 8'(mp));
    endtask
    // every answer on the wire is matched against the oldest note
    always @(u_host.got) begin
        if (exp_q.size() == 0) begin
            errors++;
            $display("unexpected at %0t: answer with nothing expected", $time);
        end else begin
            chk_w(u_host.got_v, exp_q.pop_front());
        end
    end
    // write on either port; ack notes and register mirror kept here
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] h, input int n,
                      input logic stp);
        logic        ok;
        logic        m;
        lcdsp_byte_t d;
        ok = (h[6:5] == 2'h0) && (h[4:0] <= 5'h17) && (s || !h[7]);
        m = s || (a[7:1] == {PFX, sh, sl});
        if_sel = s;
        u_host.tick(4);
        if (s) begin
            u_host.spi_on();
            u_host.spi_bits(h, 8, 1'b0);
        end else begin
            u_host.i2c_start();
            exp_q.push_back({7'h00, !m});
            u_host.i2c_byte(a, 1'b0, 1'b0);
            exp_q.push_back({7'h00, !m});
            u_host.i2c_byte(h, 1'b0, 1'b0);
        end
        if (m && ok) mp = h[4:0];
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            if (!s) exp_q.push_back({7'h00, !m});
            if (s) u_host.spi_bits(d, 8, 1'b0);
            else u_host.i2c_byte(d, 1'b0, 1'b0);
            if (m && ok && mp < 24) mreg[mp] = d;
            if (m && ok) mp = (mp < 24) ? mp + 1 : 24;
        end
        if (s) u_host.spi_off();
        else if (stp) u_host.i2c_stop();
    endtask
    // read n bytes; spi starts at pointer q, two-wire at the current one
    task automatic rd(input logic s, input logic [7:0] q, input int n);
        if_sel = s;
        u_host.tick(4);
        if (s) begin
            mp = q[4:0];
            u_host.spi_on();
            u_host.spi_bits({3'h4, q[4:0]}, 8, 1'b0);
        end else begin
            u_host.i2c_start();
            exp_q.push_back(8'h00);
            u_host.i2c_byte({PFX, sh, sl, 1'b1}, 1'b0, 1'b0);
        end
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mp < 24 ? mreg[mp] : 8'h00);
            if (s) u_host.spi_bits(8'hFF, 8, 1'b1);
            else u_host.i2c_byte(8'hFF, 1'b1, i == n - 1);
            mp = (mp < 24) ? mp + 1 : 24;
        end
        // spi has already fetched the byte after the last one
        if (s) mp = (mp < 24) ? mp + 1 : 24;
        if (s) u_host.spi_off();
    endtask
    task automatic test_done();
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        test_done();
    end
    initial begin
        rst = 1'b1;
        if_sel = 1'b0;
        sh = 1'b1;
        sl = 1'b0;
        errors = 0;
        n_tests = 0;
        mp = 0;
        foreach (mreg[k]) mreg[k] = 8'h00;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        u_host.tick(4);
        chk_all();
        wr(1'b0, {PFX, sh, sl, 1'b0}, 8'h16, 3, 1'b1);
        wr(1'b0, {PFX, !sh, !sl, 1'b0}, 8'h02, 2, 1'b1);
        wr(1'b0, {PFX, sh, sl, 1'b0}, 8'h18, 1, 1'b1);
        wr(1'b0, {PFX, sh, sl, 1'b0}, 8'h20, 1, 1'b1);
        wr(1'b0, {PFX, sh, sl, 1'b0}, 8'h15, 0, 1'b0);
        rd(1'b0, 8'h00, 4);
        chk_all();
        // every strap setting, both ports, random pointers and data
        for (int k = 0; k < 8; k++) begin
            {sh, sl} = 2'(k);
            p = 8'(rnd() % 22);
            wr(k[0], {PFX, sh, sl, 1'b0}, p, 2, 1'b1);
            wr(1'b0, {PFX, sh, sl, 1'b0}, p, 0, 1'b0);
            rd(1'b0, 8'h00, 3);
            rd(1'b1, p, 3);
            chk_all();
        end
        wr(1'b1, 8'h00, 8'h23, 2, 1'b1);
        wr(1'b1, 8'h00, 8'h43, 1, 1'b1);
        wr(1'b1, 8'h00, 8'h18, 1, 1'b1);
        chk_all();
        // enable rises in mid-byte: nothing stored, line released
        u_host.spi_on();
        u_host.spi_bits(8'h01, 8, 1'b0);
        u_host.spi_bits(8'hFF, 5, 1'b0);
        u_host.spi_off();
        mp = 1;
        chk_all();
        chk_s({7'h00, sdio_oe}, 8'h00);
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) u_host.tick(1);
        if (exp_q.size() > 0) begin
            errors++;
            $display("unexpected at %0t: answers missing", $time);
        end
        test_done();
    end
endmodule
